// >>> src/stepper_otp_pkg.sv
/*
 * Constants, types and helpers shared by the stepper drive and configuration store.
 * Assumes a 100 MHz system clock and a six-bit configuration bit address space.
 */
package stepper_otp_pkg;

    localparam int CFG_ADDR_W = 6;
    localparam int CFG_BITS = 64;
    localparam int DIV_W = 12;
    localparam int PULSE_W = 24;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration bit addresses; fields put their least significant bit lowest.

    localparam logic [CFG_ADDR_W-1:0] ADDR_CONFIG_LOCK = 6'h00;
    localparam logic [CFG_ADDR_W-1:0] ADDR_CLOCK_RANGE = 6'h01;
    localparam logic [CFG_ADDR_W-1:0] ADDR_LONG_PULSE = 6'h02;
    localparam logic [CFG_ADDR_W-1:0] ADDR_LED_SCALE = 6'h03;
    localparam logic [CFG_ADDR_W-1:0] ADDR_EXTRA_GAIN = 6'h04;
    localparam logic [CFG_ADDR_W-1:0] ADDR_SENSOR_TYPE = 6'h05;
    localparam logic [CFG_ADDR_W-1:0] ADDR_STEPPER_RATIO = 6'h0E;
    localparam int SENSOR_TYPE_W = 2;
    localparam int STEPPER_RATIO_W = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Command byte layout: value, permanent flag, bit address.

    localparam int CMD_VALUE_BIT = 7;
    localparam int CMD_PERM_BIT = 6;
    localparam logic [CFG_BITS-1:0] CFG_RESET = 64'h0000_0000_0000_0000;

    typedef enum logic [1:0] {
        CMD_IDLE = 2'b00,
        CMD_WRITE = 2'b01,
        CMD_LOCKED = 2'b10
    } cmd_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Divisors of the active-energy pulse rate.

    localparam logic [DIV_W-1:0] DIV_S0 = 12'h040;
    localparam logic [DIV_W-1:0] DIV_S1 = 12'h080;
    localparam logic [DIV_W-1:0] DIV_S2 = 12'h020;
    localparam logic [DIV_W-1:0] DIV_S3 = 12'h100;
    localparam logic [DIV_W-1:0] DIV_L0 = 12'h280;
    localparam logic [DIV_W-1:0] DIV_L1 = 12'h500;
    localparam logic [DIV_W-1:0] DIV_L2 = 12'h140;
    localparam logic [DIV_W-1:0] DIV_L3 = 12'hA00;

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse widths.

    localparam real CLK_PERIOD_NS = 10.0;
    localparam real SHORT_PULSE_MS = 31.25;
    localparam real LONG_PULSE_MS = 156.25;
    localparam int SHORT_PULSE_CYCLES = int'($floor(SHORT_PULSE_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int LONG_PULSE_CYCLES = int'($floor(LONG_PULSE_MS * 1.0e6 / CLK_PERIOD_NS));

    function automatic logic [DIV_W-1:0] ratio_divisor(input logic long_sel,
                                                      input logic [1:0] ratio);
        logic [DIV_W-1:0] d;
        d = DIV_S0;
        unique case ({long_sel, ratio})
            3'h0: d = DIV_S0;
            3'h1: d = DIV_S1;
            3'h2: d = DIV_S2;
            3'h3: d = DIV_S3;
            3'h4: d = DIV_L0;
            3'h5: d = DIV_L1;
            3'h6: d = DIV_L2;
            3'h7: d = DIV_L3;
        endcase
        return d;
    endfunction : ratio_divisor

endpackage : stepper_otp_pkg

// >>> src/otp_bit_store.sv
/*
 * Sixty-four configuration bits, each a volatile shadow latch paired with an antifuse.
 * Assumes the caller refuses writes once the lock antifuse is set.
 */
`timescale 1ns/1ns
module otp_bit_store
    import stepper_otp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic [stepper_otp_pkg::CFG_ADDR_W-1:0] wr_addr_i,
    input wire logic wr_value_i,
    input wire logic wr_perm_i,
    input wire logic read_shadow_i,
    output logic [stepper_otp_pkg::CFG_BITS-1:0] cfg_o,
    output logic lock_fuse_o
);
    import stepper_otp_pkg::*;

    logic [CFG_BITS-1:0] shadow;
    logic [CFG_BITS-1:0] fuse;

    // Shadow latches are rewritable and cleared by every reset.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            shadow <= CFG_RESET;
        else if (ce_i && wr_en_i && !wr_perm_i)
            shadow[wr_addr_i] <= wr_value_i;
    end

    // An antifuse goes only from low to high; a written bit stays until reset clears it.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            fuse <= CFG_RESET;
        else if (ce_i && wr_en_i && wr_perm_i && wr_value_i)
            fuse[wr_addr_i] <= 1'b1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_o <= CFG_RESET;
            lock_fuse_o <= 1'b0;
        end
        else if (ce_i)
        begin
            cfg_o <= (read_shadow_i && !fuse[ADDR_CONFIG_LOCK]) ? shadow : fuse;
            // Raised in the cycle the lock antifuse is written, so the next strobe is refused.
            lock_fuse_o <= fuse[ADDR_CONFIG_LOCK]
                || (wr_en_i && wr_perm_i && wr_value_i && wr_addr_i == ADDR_CONFIG_LOCK);
        end
    end

endmodule : otp_bit_store

// >>> src/pulse_stretch.sv
/*
 * Mono-flop: a trigger starts a high pulse of a given number of cycles.
 * Assumes triggers are one-cycle pulses; triggers during a pulse are ignored.
 */
`timescale 1ns/1ns
module pulse_stretch #(
    parameter int CNT_W = 24
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic trigger_i,
    input wire logic [CNT_W-1:0] length_i,
    output logic pulse_o
);

    logic [CNT_W-1:0] remain;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            remain <= '0;
            pulse_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!pulse_o && trigger_i)
            begin
                remain <= length_i - 1'b1;
                pulse_o <= 1'b1;
            end
            else if (pulse_o)
            begin
                if (remain == '0)
                    pulse_o <= 1'b0;
                remain <= (remain == '0) ? '0 : remain - 1'b1;
            end
        end
    end

endmodule : pulse_stretch

// >>> src/stepper_drive_otp_config.sv
/*
 * Stepper drive and LED output derived from the active-energy pulse, steered by
 * a configuration store of shadow latches and antifuses written by byte commands.
 * Assumes all inputs come from logic on clk_i and command bytes are one-cycle strobes.
 */
// Functional notes
// - Phase signals come from the energy pulse via divider, decoder, mono-flop, to motor pins.
// - Stepper pulse width is 31.25 ms, or 156.25 ms with long-pulse select set.
// - Divide ratio 64,128,32,256 by ratio code; ten times larger with long pulses.
// - Divided pulses alternate between the two phases, each at half rate.
// - Negative power inverts both motor pin outputs to reverse the motor.
// - No-load holds both motor pins low.
// - Every shadow latch clears on reset.
// - Each bit is a shadow latch plus antifuse; blank antifuse reads low.
// - A written antifuse holds until reset clears it; shadow latches rewrite freely.
// - Read-source set selects shadow latches, cleared selects antifuses.
// - Once the lock antifuse is set, all commands are refused, shadows unused.
// - Lock bit at address 0: low allows test mode, high normal; only its antifuse, not its shadow latch, stops writes.
// - Clock-range bit at address 1: low means 4 MHz range, high 8 MHz.
// - LED scale bit at address 3: low passes P, high divides by ratio code.
// - Sensor-type field at addresses 5-6 picks sensor kind; extra-gain raises gains.
// - Stepper ratio field sits at addresses 14 and 15.
`timescale 1ns/1ns
module stepper_drive_otp_config
    import stepper_otp_pkg::*;
#(
    parameter int SHORT_CYCLES = stepper_otp_pkg::SHORT_PULSE_CYCLES,
    parameter int LONG_CYCLES = stepper_otp_pkg::LONG_PULSE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic active_energy_pulse_i,
    input wire logic power_negative_i,
    input wire logic no_load_i,
    input wire logic read_source_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_byte_i,
    output logic motor_pos_pin_o,
    output logic motor_neg_pin_o,
    output logic led_pin_o,
    output logic config_lock_o,
    output logic test_mode_o,
    output logic clock_range_select_o,
    output logic led_scale_select_o,
    output logic long_pulse_select_o,
    output logic extra_gain_o,
    output logic [stepper_otp_pkg::SENSOR_TYPE_W-1:0] sensor_type_select_o,
    output logic [stepper_otp_pkg::STEPPER_RATIO_W-1:0] stepper_ratio_select_o,
    output logic cmd_accepted_o,
    output logic cmd_refused_o
);
    import stepper_otp_pkg::*;

    localparam logic [PULSE_W-1:0] SHORT_LEN = PULSE_W'(SHORT_CYCLES);
    localparam logic [PULSE_W-1:0] LONG_LEN = PULSE_W'(LONG_CYCLES);

    ////////////////////////////////////////////////////////////////////////////////
    // Command handling.

    cmd_state_t state;
    cmd_state_t next_state;
    logic [7:0] cmd_hold;
    logic wr_en;
    logic [CFG_BITS-1:0] cfg;
    logic lock_fuse;

    always_comb
    begin
        next_state = state;
        unique case (state)
            CMD_IDLE:
            begin
                if (lock_fuse)
                    next_state = CMD_LOCKED;
                else if (cmd_valid_i)
                    next_state = CMD_WRITE;
            end
            CMD_WRITE:
                next_state = CMD_IDLE;
            CMD_LOCKED:
                next_state = CMD_LOCKED;
            default:
                next_state = CMD_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state <= CMD_IDLE;
        else if (ce_i)
            state <= next_state;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cmd_hold <= 8'h00;
        else if (ce_i && state == CMD_IDLE && cmd_valid_i && !lock_fuse)
            cmd_hold <= cmd_byte_i;
    end

    assign wr_en = (state == CMD_WRITE);

    // A command seen while locked, or while a write is still in progress, is refused.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cmd_accepted_o <= 1'b0;
            cmd_refused_o <= 1'b0;
        end
        else if (ce_i)
        begin
            cmd_accepted_o <= cmd_valid_i && state == CMD_IDLE && !lock_fuse;
            cmd_refused_o <= cmd_valid_i && (state != CMD_IDLE || lock_fuse);
        end
    end

    otp_bit_store u_store (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .wr_en_i(wr_en),
        .wr_addr_i(cmd_hold[CFG_ADDR_W-1:0]),
        .wr_value_i(cmd_hold[CMD_VALUE_BIT]),
        .wr_perm_i(cmd_hold[CMD_PERM_BIT]),
        .read_shadow_i(read_source_i),
        .cfg_o(cfg),
        .lock_fuse_o(lock_fuse)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded configuration fields.

    logic lock_sel;
    logic long_sel;
    logic led_scale;
    logic [STEPPER_RATIO_W-1:0] ratio_sel;

    assign lock_sel = cfg[ADDR_CONFIG_LOCK];
    assign long_sel = cfg[ADDR_LONG_PULSE];
    assign led_scale = cfg[ADDR_LED_SCALE];
    assign ratio_sel = cfg[ADDR_STEPPER_RATIO +: STEPPER_RATIO_W];

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            config_lock_o <= 1'b0;
            test_mode_o <= 1'b1;
            clock_range_select_o <= 1'b0;
            led_scale_select_o <= 1'b0;
            long_pulse_select_o <= 1'b0;
            extra_gain_o <= 1'b0;
            sensor_type_select_o <= '0;
            stepper_ratio_select_o <= '0;
        end
        else if (ce_i)
        begin
            config_lock_o <= lock_sel;
            test_mode_o <= !lock_sel;
            clock_range_select_o <= cfg[ADDR_CLOCK_RANGE];
            led_scale_select_o <= led_scale;
            long_pulse_select_o <= long_sel;
            extra_gain_o <= cfg[ADDR_EXTRA_GAIN];
            sensor_type_select_o <= cfg[ADDR_SENSOR_TYPE +: SENSOR_TYPE_W];
            stepper_ratio_select_o <= ratio_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Energy pulse edge detection.

    logic energy_q;
    logic energy_rise;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            energy_q <= 1'b0;
        else if (ce_i)
            energy_q <= active_energy_pulse_i;
    end

    assign energy_rise = active_energy_pulse_i && !energy_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Stepper divider; a change of divisor restarts the count so it never overruns.

    logic [DIV_W-1:0] motor_div;
    logic [DIV_W-1:0] motor_div_q;
    logic [DIV_W-1:0] motor_cnt;
    logic motor_tick;

    assign motor_div = ratio_divisor(long_sel, ratio_sel);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            motor_cnt <= '0;
            motor_div_q <= DIV_S0;
            motor_tick <= 1'b0;
        end
        else if (ce_i)
        begin
            motor_div_q <= motor_div;
            motor_tick <= 1'b0;
            if (motor_div != motor_div_q)
                motor_cnt <= '0;
            else if (energy_rise)
            begin
                if (motor_cnt == motor_div - 1'b1)
                begin
                    motor_cnt <= '0;
                    motor_tick <= 1'b1;
                end
                else
                    motor_cnt <= motor_cnt + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decoder: divided pulses go to phase A and phase B in turn.

    logic phase_sel;
    logic trig_a;
    logic trig_b;
    logic stepper_phase_a;
    logic stepper_phase_b;
    logic [PULSE_W-1:0] motor_len;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            phase_sel <= 1'b0;
        else if (ce_i && motor_tick)
            phase_sel <= !phase_sel;
    end

    assign trig_a = motor_tick && !phase_sel;
    assign trig_b = motor_tick && phase_sel;
    assign motor_len = long_sel ? LONG_LEN : SHORT_LEN;

    pulse_stretch #(
        .CNT_W(PULSE_W)
    ) u_mono_a (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .trigger_i(trig_a),
        .length_i(motor_len),
        .pulse_o(stepper_phase_a)
    );

    pulse_stretch #(
        .CNT_W(PULSE_W)
    ) u_mono_b (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .trigger_i(trig_b),
        .length_i(motor_len),
        .pulse_o(stepper_phase_b)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Motor pins; no-load takes priority over the direction inversion.

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            motor_pos_pin_o <= 1'b0;
            motor_neg_pin_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (no_load_i)
            begin
                motor_pos_pin_o <= 1'b0;
                motor_neg_pin_o <= 1'b0;
            end
            else
            begin
                motor_pos_pin_o <= stepper_phase_a ^ power_negative_i;
                motor_neg_pin_o <= stepper_phase_b ^ power_negative_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // LED output: full rate, or divided with fixed-width pulses when scaled.

    logic [DIV_W-1:0] led_div;
    logic [DIV_W-1:0] led_div_q;
    logic [DIV_W-1:0] led_cnt;
    logic led_tick;
    logic led_pulse;

    assign led_div = ratio_divisor(1'b0, ratio_sel);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            led_cnt <= '0;
            led_div_q <= DIV_S0;
            led_tick <= 1'b0;
        end
        else if (ce_i)
        begin
            led_div_q <= led_div;
            led_tick <= 1'b0;
            if (led_div != led_div_q || !led_scale)
                led_cnt <= '0;
            else if (energy_rise)
            begin
                if (led_cnt == led_div - 1'b1)
                begin
                    led_cnt <= '0;
                    led_tick <= 1'b1;
                end
                else
                    led_cnt <= led_cnt + 1'b1;
            end
        end
    end

    pulse_stretch #(
        .CNT_W(PULSE_W)
    ) u_mono_led (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .trigger_i(led_tick),
        .length_i(SHORT_LEN),
        .pulse_o(led_pulse)
    );

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            led_pin_o <= 1'b0;
        else if (ce_i)
            led_pin_o <= led_scale ? led_pulse : active_energy_pulse_i;
    end

endmodule : stepper_drive_otp_config

// >>> tb/stepper_drive_otp_config_asserts.sv
/*
 * Port-level checker for the stepper drive and configuration store.
 * Assumes it is bound to the top module and that all ports share clk_i.
 */
`timescale 1ns/1ns
module stepper_drive_otp_config_asserts #(
    parameter int SHORT_CYCLES = 20,
    parameter int LONG_CYCLES = 50
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic power_negative_i,
    input wire logic no_load_i,
    input wire logic cmd_valid_i,
    input wire logic motor_pos_pin_o,
    input wire logic motor_neg_pin_o,
    input wire logic config_lock_o,
    input wire logic test_mode_o,
    input wire logic long_pulse_select_o,
    input wire logic cmd_accepted_o,
    input wire logic cmd_refused_o
);
    int hi_cnt;

    // Counts how long the positive pin has been high while driving forward.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hi_cnt <= 0;
        end
        else
        begin
            hi_cnt <= (motor_pos_pin_o && !power_negative_i && !no_load_i) ? hi_cnt + 1 : 0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence strobe_s;
        cmd_valid_i && ce_i;
    endsequence
    sequence answer_s;
        cmd_accepted_o ^ cmd_refused_o;
    endsequence
    sequence back2back_s;
        strobe_s ##1 (cmd_valid_i && cmd_accepted_o);
    endsequence
    sequence pos_fall_s;
        $fell(motor_pos_pin_o) && hi_cnt > 2;
    endsequence

    answer_once_a: assert property (strobe_s |=> answer_s)
        else $error("command got no single answer");
    no_answer_a: assert property (!cmd_valid_i |=> !cmd_accepted_o && !cmd_refused_o)
        else $error("answer without a command");
    busy_refused_a: assert property (back2back_s |=> cmd_refused_o)
        else $error("second strobe during a write was not refused");
    locked_refused_a: assert property (config_lock_o && cmd_valid_i |=> cmd_refused_o)
        else $error("command taken after lock");
    lock_sticky_a: assert property (config_lock_o |=> config_lock_o)
        else $error("lock bit cleared");
    test_mode_a: assert property (test_mode_o != config_lock_o)
        else $error("test mode does not follow lock bit");
    no_load_low_a: assert property (no_load_i && $past(no_load_i) |-> !motor_pos_pin_o && !motor_neg_pin_o)
        else $error("motor pin high under no load");
    pulse_width_a: assert property (pos_fall_s |-> hi_cnt == (long_pulse_select_o ? LONG_CYCLES : SHORT_CYCLES))
        else $error("stepper pulse has wrong width");

endmodule : stepper_drive_otp_config_asserts

bind stepper_drive_otp_config stepper_drive_otp_config_asserts #(
    .SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)
) i_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .power_negative_i(power_negative_i),
    .no_load_i(no_load_i), .cmd_valid_i(cmd_valid_i), .motor_pos_pin_o(motor_pos_pin_o),
    .motor_neg_pin_o(motor_neg_pin_o), .config_lock_o(config_lock_o),
    .test_mode_o(test_mode_o), .long_pulse_select_o(long_pulse_select_o),
    .cmd_accepted_o(cmd_accepted_o), .cmd_refused_o(cmd_refused_o)
);

// >>> tb/stepper_motor_model.sv
/*
 * Stepper motor stand-in: counts pulses on each motor pin and the last positive width.
 * Assumes the pins are registered on clk_i.
 */
`timescale 1ns/1ns
module stepper_motor_model (
    input wire logic clk_i,
    input wire logic pos_i,
    input wire logic neg_i
);
    int n_pos = 0;
    int n_neg = 0;
    int width = 0;
    int run = 0;
    logic pos_q = 1'b0;
    logic neg_q = 1'b0;

    always @(posedge clk_i)
    begin
        pos_q <= pos_i;
        neg_q <= neg_i;
        run <= pos_i ? run + 1 : 0;
        if (pos_i && !pos_q) n_pos <= n_pos + 1;
        if (neg_i && !neg_q) n_neg <= n_neg + 1;
        if (!pos_i && pos_q) width <= run;
    end
endmodule : stepper_motor_model

// >>> tb/stepper_drive_otp_config_tb.sv
/*
 * Self-checking bench: byte commands program the store, energy pulses drive the motor.
 * Assumes short pulse counts of 20 and 50 cycles in place of the real widths.
 */
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("BAD %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module stepper_drive_otp_config_tb;
    import stepper_otp_pkg::*;
    localparam int SHORT_LEN = 20;
    localparam int LONG_LEN = 50;
    logic clk_i, rst_n_i, ce_i, aep, pneg, nload, rsrc, cvalid;
    logic [7:0] cbyte;
    logic pos, neg, led, lock, tmode, crange, lscale, lpulse, xgain, acc, ref_o;
    logic [1:0] stype, sratio;
    int n_fail = 0;
    int checks_done = 0;
    int divs [8] = '{64, 128, 32, 256, 640, 1280, 320, 2560};

    stepper_drive_otp_config #(.SHORT_CYCLES(SHORT_LEN), .LONG_CYCLES(LONG_LEN)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .active_energy_pulse_i(aep),
        .power_negative_i(pneg), .no_load_i(nload), .read_source_i(rsrc),
        .cmd_valid_i(cvalid), .cmd_byte_i(cbyte), .motor_pos_pin_o(pos),
        .motor_neg_pin_o(neg), .led_pin_o(led), .config_lock_o(lock), .test_mode_o(tmode),
        .clock_range_select_o(crange), .led_scale_select_o(lscale),
        .long_pulse_select_o(lpulse), .extra_gain_o(xgain), .sensor_type_select_o(stype),
        .stepper_ratio_select_o(sratio), .cmd_accepted_o(acc), .cmd_refused_o(ref_o));
    stepper_motor_model i_motor (.clk_i(clk_i), .pos_i(pos), .neg_i(neg));

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    // One command byte; waits until the decoded outputs show its effect.
    task automatic send(input logic v, input logic p, input logic [5:0] a, input logic ok);
        @(posedge clk_i);
        cvalid <= 1'b1;
        cbyte <= {v, p, a};
        @(posedge clk_i);
        cvalid <= 1'b0;
        #1;
        `CHK("cmd_accepted_o", ok, acc)
        `CHK("cmd_refused_o", !ok, ref_o)
        repeat (4) @(posedge clk_i);
        #1;
    endtask : send

    task automatic energy(input int n, input int len);
        repeat (n)
        begin
            @(posedge clk_i);
            aep <= 1'b1;
            @(posedge clk_i);
            aep <= 1'b0;
        end
        repeat (len + 8) @(posedge clk_i);
        #1;
    endtask : energy

    task automatic step(input int k);
        int p0;
        int q0;
        int len;
        len = k[2] ? LONG_LEN : SHORT_LEN;
        send(k[2], 1'b0, ADDR_LONG_PULSE, 1'b1);
        send(k[0], 1'b0, ADDR_STEPPER_RATIO, 1'b1);
        send(k[1], 1'b0, ADDR_STEPPER_RATIO + 6'h01, 1'b1);
        `CHK("pulse and ratio select", k[2:0], {lpulse, sratio})
        p0 = i_motor.n_pos;
        q0 = i_motor.n_neg;
        energy(2 * divs[k] - 1, len);
        `CHK("pos pulses", p0 + 1, i_motor.n_pos)
        `CHK("neg pulses", q0, i_motor.n_neg)
        `CHK("pulse width", len, i_motor.width)
        energy(1, len);
        `CHK("neg pulses", q0 + 1, i_motor.n_neg)
    endtask : step

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial
    begin
        #500_000;
        $display("BAD watchdog expected 0 seen 1");
        n_fail++;
        results();
    end

    initial
    begin
        {rst_n_i, aep, pneg, nload, cvalid, cbyte} = '0;
        ce_i = 1'b1;
        rsrc = 1'b1;
        repeat (10) @(posedge clk_i);
        #1;
        `CHK("test_mode_o", 1'b1, tmode)
        `CHK("config", 3'h0, {lock, crange, lscale})
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        $display("test reset done");
        send(1'b1, 1'b0, ADDR_CLOCK_RANGE, 1'b1);
        send(1'b1, 1'b0, ADDR_LED_SCALE, 1'b1);
        send(1'b1, 1'b0, ADDR_SENSOR_TYPE, 1'b1);
        send(1'b1, 1'b0, ADDR_EXTRA_GAIN, 1'b1);
        `CHK("shadow fields", 5'h1D, {xgain, crange, lscale, stype})
        @(posedge clk_i);
        rsrc <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        `CHK("fuse fields", 5'h00, {xgain, crange, lscale, stype})
        @(posedge clk_i);
        rsrc <= 1'b1;
        @(posedge clk_i);
        cvalid <= 1'b1;
        cbyte <= {1'b0, 1'b0, ADDR_LED_SCALE};
        @(posedge clk_i);
        cbyte <= {1'b0, 1'b0, ADDR_CLOCK_RANGE};
        #1;
        `CHK("cmd_accepted_o", 1'b1, acc)
        @(posedge clk_i);
        cvalid <= 1'b0;
        #1;
        `CHK("cmd_refused_o", 1'b1, ref_o)
        repeat (4) @(posedge clk_i);
        #1;
        `CHK("clock_range_select_o", 1'b1, crange)
        send(1'b1, 1'b0, ADDR_LED_SCALE, 1'b1);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        `CHK("shadows after reset", 5'h00, {xgain, crange, lscale, stype})
        $display("test shadow done");
        for (int k = 0; k < 8; k++) step(k);
        $display("test stepper done");
        @(posedge clk_i);
        {aep, pneg} <= 2'h3;
        @(posedge clk_i);
        #1;
        `CHK("led pin", 1'b1, led)
        @(posedge clk_i);
        aep <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        `CHK("pins negative", 2'h3, {pos, neg})
        @(posedge clk_i);
        nload <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        `CHK("pins no load", 2'h0, {pos, neg})
        @(posedge clk_i);
        {pneg, nload} <= 2'h0;
        $display("test direction done");
        @(posedge clk_i);
        rsrc <= 1'b0;
        send(1'b1, 1'b1, ADDR_CLOCK_RANGE, 1'b1);
        `CHK("fuse clock range", 1'b1, crange)
        send(1'b0, 1'b1, ADDR_CLOCK_RANGE, 1'b1);
        `CHK("fuse clock range", 1'b1, crange)
        @(posedge clk_i);
        rsrc <= 1'b1;
        send(1'b1, 1'b1, ADDR_CONFIG_LOCK, 1'b1);
        `CHK("lock and test mode", 2'h2, {lock, tmode})
        send(1'b0, 1'b0, ADDR_CLOCK_RANGE, 1'b0);
        `CHK("locked fields", 2'h2, {crange, lscale})
        $display("test fuse done");
        results();
    end
endmodule : stepper_drive_otp_config_tb
